// ==== verilog/pll_tune_test_mux_regs.svh ====
// Offsets, field positions, reset values and timing counts
//
// Function
// [R1] Bits 7:3 of the tune-time register give the retune settling time in 10 us steps, up to 310 us.
// [R2] After reset the retune settling field means 100 us.
// [R3] Bits 2:0 of the tune-time register give the post-calibration settling time in 10 us steps, up to 70 us.
// [R4] After reset the post-calibration settling field means 20 us.
// [R5] A cold start waits the retune time plus the post-calibration time before the synthesizer counts as settled.
// [R6] The tune-time register resets to 01010010 and both fields are readable and writable.
// [R7] Bits 5:2 of the boost register set the bad-preamble threshold; the window lasts threshold times 4 bit periods.
// [R8] The boost register resets to 01010100 with reserved 7:6, threshold, regulator boost at bit 1, bias boost at bit 0.
// [R9] In calibration control bit 7 reads as zero, bit 5 is the read-only ADC-calibration-done flag, the rest are read/write.
// [R10] Select 30 puts chip ready, PLL enable and transmit enable on GPIO0, GPIO1, GPIO2.
// [R11] Select 44 puts the gated modulator clock, the transmit clock and the FIFO read clock on GPIO0, GPIO1, GPIO2.
// [R12] Select 49 puts packet handler enable, valid preamble and packet searching on GPIO0, GPIO1, GPIO2.
// [R13] Select 52 puts sync detected, CRC error and header error on GPIO0, GPIO1, GPIO2.
// [R14] Select 63 puts ADC enable, ADC reference enable and combined ADC reset on GPIO0, GPIO1, GPIO2.
// [R15] Software routes a GPIO to the test multiplexer before it expects a test signal on that pin.
`ifndef PLL_TUNE_TEST_MUX_REGS_SVH
`define PLL_TUNE_TEST_MUX_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_TEST_BUS_SEL   8'h51
`define OFS_PLL_TUNE_TIME  8'h53
`define OFS_AMP_BOOST      8'h54
`define OFS_CAL_CONTROL    8'h55

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_TEST_BUS_SEL   8'h00
`define RST_PLL_TUNE_TIME  8'h52
`define RST_AMP_BOOST      8'h54
`define RST_CAL_CONTROL    8'h44

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TS_MSB             7
`define TS_LSB             3
`define TO_MSB             2
`define TO_LSB             0
`define TH_MSB             5
`define TH_LSB             2
`define BIT_REG_BOOST      1
`define BIT_BIAS_BOOST     0
`define BIT_CAL_RSVD       7
`define BIT_CAL_ADC_DONE   5
`define BIT_SCAN_EN        6
`define DTB_MSB            5

// ----------------------------------------------------------------------
// Test bus select codes
// ----------------------------------------------------------------------
`define DTB_STATE          6'h1E
`define DTB_CLOCKS         6'h2C
`define DTB_RX_SEARCH      6'h31
`define DTB_RX_ERRORS      6'h34
`define DTB_ADC            6'h3F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define SETTLE_STEP_NS     10000
`define SETTLE_STEP_CYC    (`SETTLE_STEP_NS / `CLK_PERIOD_NS)
`define BITS_PER_THRESH    4

`endif

// ==== verilog/pll_tune_test_mux_pkg.sv ====
// Types shared by the tune-time, boost and test-mux register block
`default_nettype none
package pll_tune_test_mux_pkg;

    typedef struct packed {
        logic chip_ready;
        logic pll_enable;
        logic tx_enable;
        logic mod_clk_10m;
        logic tx_clk;
        logic fifo_read_clock;
        logic rx_packet_handler_enable;
        logic valid_preamble;
        logic packet_searching;
        logic sync_detected;
        logic crc_error;
        logic header_error;
        logic adc_enable;
        logic adc_ref_enable;
        logic adc_reset_n;
    } test_sig_t;

    typedef struct packed {
        logic xtal_start_half;
        logic rc_fine_cal_en;
        logic rc_cal_force;
        logic vco_cal_double;
        logic vco_cal_force;
        logic skip_vco_cal;
    } cal_ctrl_t;

    typedef enum logic [1:0] {
        SETTLE_IDLE,
        SETTLE_RUN
    } settle_state_t;

endpackage
`default_nettype wire

// ==== verilog/pll_tune_test_mux_regs.sv ====
// Tune-time, boost and calibration registers with settle timer and test mux
//
// The implementer's own choice: the plain strobed port.
`include "pll_tune_test_mux_regs.svh"
`default_nettype none
module pll_tune_test_mux_regs
    import pll_tune_test_mux_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       retune_start,
    input  wire logic       cold_start,
    output logic            settle_busy,
    output logic            settle_done,
    input  wire logic       bit_tick,
    input  wire logic       preamble_eval_start,
    input  wire logic       preamble_found,
    output logic            preamble_window_busy,
    output logic            bad_preamble,
    output logic            regulator_amp_boost,
    output logic            amp_bias_boost,
    input  wire logic       adc_cal_done,
    output cal_ctrl_t       cal_ctrl,
    output logic            scan_test_enable,
    input  wire test_sig_t  test_sig,
    output logic      [2:0] gpio_test
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] dtb_sel_ff;
    logic [7:0] tune_ff;
    logic [7:0] boost_ff;
    logic [7:0] cal_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dtb_sel_ff <= `RST_TEST_BUS_SEL;
        end else if (wr && addr == `OFS_TEST_BUS_SEL) begin
            dtb_sel_ff <= wdata;
        end
    end

    // Both fields writable; reset gives 100 us and 20 us
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tune_ff <= `RST_PLL_TUNE_TIME; // [R2] [R4] [R6]
        end else if (wr && addr == `OFS_PLL_TUNE_TIME) begin
            tune_ff <= wdata; // [R1] [R3] [R6]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boost_ff <= `RST_AMP_BOOST; // [R8]
        end else if (wr && addr == `OFS_AMP_BOOST) begin
            boost_ff <= wdata; // [R8]
        end
    end

    // Bits 7 and 5 are never stored; bit 5 is live status
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cal_ff <= `RST_CAL_CONTROL;
        end else if (wr && addr == `OFS_CAL_CONTROL) begin
            cal_ff <= wdata & 8'h5F; // [R9]
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        unique case (addr)
            `OFS_TEST_BUS_SEL:  nxt_rdata = dtb_sel_ff;
            `OFS_PLL_TUNE_TIME: nxt_rdata = tune_ff;
            `OFS_AMP_BOOST:     nxt_rdata = boost_ff;
            `OFS_CAL_CONTROL: begin
                nxt_rdata = cal_ff; // [R9]
                nxt_rdata[`BIT_CAL_ADC_DONE] = adc_cal_done; // [R9]
            end
            default:            nxt_rdata = 8'h00;
        endcase
    end

    // Unmapped reads answer zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
        end else if (rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata               = rdata_ff;
    assign regulator_amp_boost = boost_ff[`BIT_REG_BOOST]; // [R8]
    assign amp_bias_boost      = boost_ff[`BIT_BIAS_BOOST]; // [R8]
    assign scan_test_enable    = dtb_sel_ff[`BIT_SCAN_EN];
    assign cal_ctrl            = '{
        xtal_start_half: cal_ff[6],
        rc_fine_cal_en:  cal_ff[4],
        rc_cal_force:    cal_ff[3],
        vco_cal_double:  cal_ff[2],
        vco_cal_force:   cal_ff[1],
        skip_vco_cal:    cal_ff[0]
    };

    // ------------------------------------------------------------------
    // PLL settle timer
    // ------------------------------------------------------------------
    // Fields are sampled at start, so a rewrite mid-count has no effect.
    settle_state_t state_ff;
    logic [5:0]    steps_ff;
    logic [9:0]    presc_ff;
    logic          done_ff;
    logic          step_tick;
    logic [5:0]    soft_steps;
    logic [5:0]    post_steps;

    assign soft_steps = {1'b0, tune_ff[`TS_MSB:`TS_LSB]}; // [R1]
    assign post_steps = {3'b000, tune_ff[`TO_MSB:`TO_LSB]}; // [R3]
    assign step_tick  = presc_ff == 10'(`SETTLE_STEP_CYC - 1);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SETTLE_IDLE;
            steps_ff <= 6'h00;
        end else if (cold_start) begin
            state_ff <= SETTLE_RUN;
            steps_ff <= soft_steps + post_steps; // [R5]
        end else if (retune_start) begin
            state_ff <= SETTLE_RUN;
            steps_ff <= soft_steps; // [R1]
        end else begin
            unique case (state_ff)
                SETTLE_IDLE: state_ff <= SETTLE_IDLE;
                SETTLE_RUN: begin
                    if (steps_ff == 6'h00) begin
                        state_ff <= SETTLE_IDLE;
                    end else if (step_tick) begin
                        steps_ff <= steps_ff - 6'h01;
                    end
                end
                default: state_ff <= SETTLE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            presc_ff <= 10'h000;
        end else if (cold_start || retune_start || step_tick
                     || state_ff != SETTLE_RUN) begin
            presc_ff <= 10'h000;
        end else begin
            presc_ff <= presc_ff + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= state_ff == SETTLE_RUN && steps_ff == 6'h00
                       && !cold_start && !retune_start; // [R5]
        end
    end

    assign settle_busy = state_ff == SETTLE_RUN;
    assign settle_done = done_ff;

    // ------------------------------------------------------------------
    // Bad-preamble window
    // ------------------------------------------------------------------
    logic       pre_busy_ff;
    logic [5:0] pre_bits_ff;
    logic [5:0] pre_limit_ff;
    logic       bad_pre_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_busy_ff  <= 1'b0;
            pre_bits_ff  <= 6'h00;
            pre_limit_ff <= 6'h00;
        end else if (preamble_eval_start) begin
            pre_busy_ff  <= 1'b1;
            pre_bits_ff  <= 6'h00;
            pre_limit_ff <= 6'({boost_ff[`TH_MSB:`TH_LSB], 2'b00}); // [R7]
        end else if (pre_busy_ff) begin
            if (preamble_found || pre_bits_ff == pre_limit_ff) begin
                pre_busy_ff <= 1'b0;
            end else if (bit_tick) begin
                pre_bits_ff <= pre_bits_ff + 6'h01; // [R7]
            end
        end
    end

    // A preamble seen on the closing cycle still counts as found
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bad_pre_ff <= 1'b0;
        end else begin
            bad_pre_ff <= pre_busy_ff && !preamble_eval_start
                          && !preamble_found
                          && pre_bits_ff == pre_limit_ff; // [R7]
        end
    end

    assign preamble_window_busy = pre_busy_ff;
    assign bad_preamble         = bad_pre_ff;

    // ------------------------------------------------------------------
    // Digital test bus, upper codes
    // ------------------------------------------------------------------
    // Registered so the pins never glitch while the select changes.
    // Codes not listed here drive zero. Pins need routing by software.
    logic [2:0] gpio_ff;
    logic [2:0] nxt_gpio;

    always_comb begin
        nxt_gpio = 3'h0;
        unique case (dtb_sel_ff[`DTB_MSB:0])
            `DTB_STATE: nxt_gpio = {test_sig.tx_enable,
                                    test_sig.pll_enable,
                                    test_sig.chip_ready}; // [R10]
            `DTB_CLOCKS: nxt_gpio = {test_sig.fifo_read_clock,
                                     test_sig.tx_clk,
                                     test_sig.mod_clk_10m}; // [R11]
            `DTB_RX_SEARCH: nxt_gpio = {test_sig.packet_searching,
                test_sig.valid_preamble,
                test_sig.rx_packet_handler_enable}; // [R12]
            `DTB_RX_ERRORS: nxt_gpio = {test_sig.header_error,
                                        test_sig.crc_error,
                                        test_sig.sync_detected}; // [R13]
            `DTB_ADC: nxt_gpio = {test_sig.adc_reset_n,
                                  test_sig.adc_ref_enable,
                                  test_sig.adc_enable}; // [R14]
            default: nxt_gpio = 3'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_ff <= 3'h0;
        end else begin
            gpio_ff <= nxt_gpio;
        end
    end

    assign gpio_test = gpio_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [15:0] elapsed_ff;
    logic [15:0] expect_ff;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            elapsed_ff <= 16'h0000;
            expect_ff  <= 16'h0000;
        end else if (cold_start || retune_start) begin
            elapsed_ff <= 16'h0000;
            expect_ff  <= 16'((cold_start ? 32'(soft_steps + post_steps)
                                          : 32'(soft_steps))
                              * `SETTLE_STEP_CYC);
        end else if (settle_busy) begin
            elapsed_ff <= elapsed_ff + 16'h0001;
        end
    end

    property p_settle_time;
        settle_done |-> elapsed_ff == expect_ff + 16'h0001;
    endproperty
    a_settle_time: assert property (p_settle_time) // [R5]
        else $error("settle time does not match tune fields");

    property p_retune_load;
        retune_start && !cold_start |=>
            steps_ff == $past(soft_steps) && settle_busy;
    endproperty
    a_retune_load: assert property (p_retune_load) // [R1]
        else $error("retune does not load soft settle steps");

    property p_cold_load;
        cold_start |=> steps_ff == $past(soft_steps) + $past(post_steps);
    endproperty
    a_cold_load: assert property (p_cold_load) // [R3]
        else $error("cold start does not add post-cal steps");

    property p_tune_read;
        wr && addr == `OFS_PLL_TUNE_TIME ##1 rd && addr == `OFS_PLL_TUNE_TIME
            |=> rdata == $past(wdata, 2);
    endproperty
    a_tune_read: assert property (p_tune_read) // [R6]
        else $error("tune time readback differs from write");

    property p_bad_pre_bits;
        bad_preamble |-> pre_bits_ff == 6'({$past(pre_limit_ff)});
    endproperty
    a_bad_pre_bits: assert property (p_bad_pre_bits) // [R7]
        else $error("bad preamble before threshold x4 bits");

    property p_boost_pins;
        ##1 regulator_amp_boost == boost_ff[1] && amp_bias_boost == boost_ff[0]
            && (!$past(wr) || $past(addr) != `OFS_AMP_BOOST
                || boost_ff == $past(wdata));
    endproperty
    a_boost_pins: assert property (p_boost_pins) // [R8]
        else $error("boost register or pins wrong");

    property p_cal_read;
        rd && addr == `OFS_CAL_CONTROL |=>
            !rdata[7] && rdata[5] == $past(adc_cal_done);
    endproperty
    a_cal_read: assert property (p_cal_read) // [R9]
        else $error("calibration control read-only bits wrong");

    property p_mux_state;
        dtb_sel_ff[5:0] == `DTB_STATE |=> gpio_test ==
            $past({test_sig.tx_enable, test_sig.pll_enable,
                   test_sig.chip_ready});
    endproperty
    a_mux_state: assert property (p_mux_state) // [R10]
        else $error("select 30 output wrong");

    property p_mux_clocks;
        dtb_sel_ff[5:0] == `DTB_CLOCKS |=> gpio_test ==
            $past({test_sig.fifo_read_clock, test_sig.tx_clk,
                   test_sig.mod_clk_10m});
    endproperty
    a_mux_clocks: assert property (p_mux_clocks) // [R11]
        else $error("select 44 output wrong");

    property p_mux_search;
        dtb_sel_ff[5:0] == `DTB_RX_SEARCH |=> gpio_test ==
            $past({test_sig.packet_searching, test_sig.valid_preamble,
                   test_sig.rx_packet_handler_enable});
    endproperty
    a_mux_search: assert property (p_mux_search) // [R12]
        else $error("select 49 output wrong");

    property p_mux_errors;
        dtb_sel_ff[5:0] == `DTB_RX_ERRORS |=> gpio_test ==
            $past({test_sig.header_error, test_sig.crc_error,
                   test_sig.sync_detected});
    endproperty
    a_mux_errors: assert property (p_mux_errors) // [R13]
        else $error("select 52 output wrong");

    property p_mux_adc;
        dtb_sel_ff[5:0] == `DTB_ADC |=> gpio_test ==
            $past({test_sig.adc_reset_n, test_sig.adc_ref_enable,
                   test_sig.adc_enable});
    endproperty
    a_mux_adc: assert property (p_mux_adc) // [R14]
        else $error("select 63 output wrong");

    c_cold_settle: cover property (cold_start ##[1:1000] settle_busy);
    c_bad_pre:     cover property (preamble_eval_start ##[1:100] bad_preamble);
    c_mux_adc:     cover property (dtb_sel_ff[5:0] == `DTB_ADC ##1 gpio_test[0]);

endmodule // pll_tune_test_mux_regs
`default_nettype wire

// ==== test/pll_tune_test_mux_regs_tb.sv ====
// Self-checking bench for the tune-time, boost and test-mux registers
`include "pll_tune_test_mux_regs.svh"
`default_nettype none
module pll_tune_test_mux_regs_tb
    import pll_tune_test_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       arst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       retune_start;
    logic       cold_start;
    logic       settle_busy;
    logic       settle_done;
    logic       bit_tick;
    logic       preamble_eval_start;
    logic       preamble_found;
    logic       preamble_window_busy;
    logic       bad_preamble;
    logic       regulator_amp_boost;
    logic       amp_bias_boost;
    logic       adc_cal_done;
    cal_ctrl_t  cal_ctrl;
    logic       scan_test_enable;
    test_sig_t  test_sig;
    logic [2:0] gpio_test;
    int         fail_count;
    int         checks_done;
    logic [7:0] rv;

    pll_tune_test_mux_regs uut (
        .clk                  (clk),
        .arst_n               (arst_n),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .retune_start         (retune_start),
        .cold_start           (cold_start),
        .settle_busy          (settle_busy),
        .settle_done          (settle_done),
        .bit_tick             (bit_tick),
        .preamble_eval_start  (preamble_eval_start),
        .preamble_found       (preamble_found),
        .preamble_window_busy (preamble_window_busy),
        .bad_preamble         (bad_preamble),
        .regulator_amp_boost  (regulator_amp_boost),
        .amp_bias_boost       (amp_bias_boost),
        .adc_cal_done         (adc_cal_done),
        .cal_ctrl             (cal_ctrl),
        .scan_test_enable     (scan_test_enable),
        .test_sig             (test_sig),
        .gpio_test            (gpio_test)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ----------------------------------------------------------------------
    // Access and check tasks
    // ----------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // Read data appear in the cycle after the strobe and hold until the next read strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Write strobe followed by a read strobe with no gap between them
    task automatic wr_rd_reg(input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q);
        wr_reg(a, d);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask

    // Returns cycles from the one that holds the start pulse to settle_done
    task automatic settle_run(input logic cold, output int n);
        @(posedge clk);
        cold_start   <= cold;
        retune_start <= ~cold;
        @(posedge clk);
        cold_start   <= 1'b0;
        retune_start <= 1'b0;
        #1;
        check("settle_busy", 16'(settle_busy), 16'h1);
        for (n = 2; n < 40000; n++) begin
            @(posedge clk);
            #1;
            if (settle_done === 1'b1) return;
        end
        fail_count++;
        test_done();
    endtask

    task automatic pulse_input(input int which);
        @(posedge clk);
        if (which == 0) preamble_eval_start <= 1'b1;
        if (which == 1) bit_tick <= 1'b1;
        if (which == 2) preamble_found <= 1'b1;
        @(posedge clk);
        preamble_eval_start <= 1'b0;
        bit_tick            <= 1'b0;
        preamble_found      <= 1'b0;
        #1;
    endtask

    function automatic logic [2:0] mux_exp(input logic [5:0] c,
                                           input test_sig_t s);
        case (c)
            `DTB_STATE:     return {s.tx_enable, s.pll_enable, s.chip_ready};
            `DTB_CLOCKS:    return {s.fifo_read_clock, s.tx_clk, s.mod_clk_10m};
            `DTB_RX_SEARCH: return {s.packet_searching, s.valid_preamble,
                                    s.rx_packet_handler_enable};
            `DTB_RX_ERRORS: return {s.header_error, s.crc_error,
                                    s.sync_detected};
            `DTB_ADC:       return {s.adc_reset_n, s.adc_ref_enable,
                                    s.adc_enable};
            default:        return 3'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    logic [5:0] codes [7] = '{`DTB_STATE, `DTB_CLOCKS, `DTB_RX_SEARCH,
                              `DTB_RX_ERRORS, `DTB_ADC, 6'h00, 6'h1F};
    logic [14:0] pats [3] = '{15'h5555, 15'h2AAA, 15'h4924};

    initial begin
        int n;
        int k;
        logic [2:0] e;
        fail_count = 0;
        checks_done = 0;
        arst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        retune_start = 1'b0;
        cold_start = 1'b0;
        bit_tick = 1'b0;
        preamble_eval_start = 1'b0;
        preamble_found = 1'b0;
        adc_cal_done = 1'b0;
        test_sig = '0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;

        rd_reg(`OFS_PLL_TUNE_TIME, rv);
        check("tune reset", 16'(rv), 16'h52);
        rd_reg(`OFS_AMP_BOOST, rv);
        check("boost reset", 16'(rv), 16'h54);
        rd_reg(`OFS_CAL_CONTROL, rv);
        check("cal reset", 16'(rv), 16'h44);
        check("cal_ctrl reset", 16'(cal_ctrl), 16'h24);
        check("boost pins", 16'({regulator_amp_boost, amp_bias_boost}),
              16'h0);
        rd_reg(8'h60, rv);
        check("unmapped", 16'(rv), 16'h00);

        wr_rd_reg(`OFS_PLL_TUNE_TIME, 8'hFF, rv);
        check("tune rw", 16'(rv), 16'hFF);
        wr_reg(`OFS_AMP_BOOST, 8'h03);
        rd_reg(`OFS_AMP_BOOST, rv);
        check("boost rw", 16'(rv), 16'h03);
        check("boost pins", 16'({regulator_amp_boost, amp_bias_boost}),
              16'h3);
        wr_reg(`OFS_CAL_CONTROL, 8'hFF);
        rd_reg(`OFS_CAL_CONTROL, rv);
        check("cal ro bits", 16'(rv), 16'h5F);
        check("cal_ctrl", 16'(cal_ctrl), 16'h3F);
        @(posedge clk);
        adc_cal_done <= 1'b1;
        rd_reg(`OFS_CAL_CONTROL, rv);
        check("cal done flag", 16'(rv), 16'h7F);

        // Settle timer: Ts = 1 step, To = 2 steps, then both zero
        wr_reg(`OFS_PLL_TUNE_TIME, 8'h0A);
        settle_run(1'b0, n);
        check("retune time", 16'(n), 16'(`SETTLE_STEP_CYC + 2));
        settle_run(1'b1, n);
        check("cold time", 16'(n), 16'(3 * `SETTLE_STEP_CYC + 2));
        wr_reg(`OFS_PLL_TUNE_TIME, 8'h00);
        settle_run(1'b1, n);
        check("zero time", 16'(n), 16'h2);

        // Threshold 1 gives a window of four bit ticks
        wr_reg(`OFS_AMP_BOOST, 8'h04);
        pulse_input(0);
        check("window busy", 16'(preamble_window_busy), 16'h1);
        for (k = 0; k < 3; k++) begin
            pulse_input(1);
            check("early bad", 16'(bad_preamble), 16'h0);
            check("early busy", 16'(preamble_window_busy), 16'h1);
        end
        pulse_input(1);
        for (n = 0; n < 4 && bad_preamble !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        check("bad preamble", 16'(bad_preamble), 16'h1);
        pulse_input(0);
        pulse_input(1);
        pulse_input(2);
        check("found closes", 16'(preamble_window_busy), 16'h0);
        for (k = 0; k < 6; k++) begin
            pulse_input(1);
            check("found no bad", 16'(bad_preamble), 16'h0);
        end

        // Select is routed before the pins are looked at
        for (int c = 0; c < 7; c++) begin
            wr_reg(`OFS_TEST_BUS_SEL, {2'b00, codes[c]});
            for (int p = 0; p < 3; p++) begin
                @(posedge clk);
                test_sig <= test_sig_t'(pats[p]);
                repeat (2) @(posedge clk);
                #1;
                e = mux_exp(codes[c], test_sig);
                check("gpio_test", 16'(gpio_test),
                      16'(e));
            end
        end
        wr_reg(`OFS_TEST_BUS_SEL, 8'hDE);
        rd_reg(`OFS_TEST_BUS_SEL, rv);
        check("test sel rw", 16'(rv), 16'hDE);
        check("scan enable", 16'(scan_test_enable), 16'h1);
        test_done();
    end
endmodule // pll_tune_test_mux_regs_tb
`default_nettype wire
